// *** rtl/flps_pkg.sv ***
// Constants, types and helpers of the flash protect and program/erase sequencer
// Operation
// [R1] Option bit 0 blocks user program/erase
// [R2] Option bit 1 permits all program/erase
// [R3] Reset enters locked state
// [R4] Software: page, 73H, 8CH, page again
// [R5] Page writes compared; match opens page
// [R6] 95H erases page only if sector free
// [R7] Other command relocks, closes page
// [R8] Byte writes in open page keep it open
// [R9] Eight sectors, never smaller than page
// [R10] Sector protect clears on reset
// [R11] 5EH routes shared address to protect
// [R12] Other command routes back to page select
// [R13] User protect writes only set bits
// [R14] Protected sector blocks CPU program/erase
// [R15] Set protect bit stays set
// [R16] Software: 00H, 5EH, access, 00H
// [R17] Programming clears bits; erase sets FFH
// [R18] Software programs byte at most twice
// [R19] CPU stalled during program or erase
// [R20] Page erase fills page, then relocks
// [R21] Debugger 63H mass erase, then relocks
// [R22] Debugger ignores guards, may clear protect
// [R23] Debugger skips second page write
// [R24] Software reopens each page separately
// [R25] State code reports controller state
// [R26] Page field gives address bits 15:9
`default_nettype none
package flps_pkg;
  localparam logic [11:0] FLPS_CTL_ADDR = 12'hFF8;
  localparam logic [11:0] FLPS_SEL_ADDR = 12'hFF9;
  localparam logic [7:0] FLPS_CMD_UNL1 = 8'h73;
  localparam logic [7:0] FLPS_CMD_UNL2 = 8'h8C;
  localparam logic [7:0] FLPS_CMD_PERASE = 8'h95;
  localparam logic [7:0] FLPS_CMD_MERASE = 8'h63;
  localparam logic [7:0] FLPS_CMD_PROT = 8'h5E;
  localparam logic [5:0] FLPS_ST_LOCKED = 6'h00;
  localparam logic [5:0] FLPS_ST_GOT1 = 6'h01;
  localparam logic [5:0] FLPS_ST_GOT2 = 6'h02;
  localparam logic [5:0] FLPS_ST_OPEN = 6'h03;
  localparam logic [5:0] FLPS_ST_PROT = 6'h04;
  localparam logic [5:0] FLPS_ST_PROG = 6'h08;
  localparam logic [5:0] FLPS_ST_PERASE = 6'h10;
  localparam logic [5:0] FLPS_ST_MERASE = 6'h20;
  localparam int FLPS_PAGE_LSB = 9;
  localparam int FLPS_PAGE_BYTES = 512;
  localparam int FLPS_SECTORS = 8;
  localparam logic [7:0] FLPS_PROT_RESET = 8'h00;
  localparam logic [7:0] FLPS_SEL_RESET = 8'h00;
  localparam logic [1:0] FLPS_RSVD = 2'h0;
  localparam logic [8:0] FLPS_PAGE_OFS = 9'h000;
  localparam logic [15:0] FLPS_TIME_RESET = 16'h0000;

  typedef enum logic [2:0] {
    FLPS_LOCKED, FLPS_GOT1, FLPS_GOT2, FLPS_OPEN,
    FLPS_PROT, FLPS_PROG, FLPS_PERASE, FLPS_MERASE
  } flps_state_t;

  // State code seen by software
  function automatic logic [5:0] flps_status(input flps_state_t s);
    case (s)
      FLPS_GOT1: flps_status = FLPS_ST_GOT1;
      FLPS_GOT2: flps_status = FLPS_ST_GOT2;
      FLPS_OPEN: flps_status = FLPS_ST_OPEN;
      FLPS_PROT: flps_status = FLPS_ST_PROT;
      FLPS_PROG: flps_status = FLPS_ST_PROG;
      FLPS_PERASE: flps_status = FLPS_ST_PERASE;
      FLPS_MERASE: flps_status = FLPS_ST_MERASE;
      default: flps_status = FLPS_ST_LOCKED;
    endcase
  endfunction : flps_status

  // Sector index of a program address
  function automatic logic [2:0] flps_sector(input logic [15:0] a, input int sh);
    logic [15:0] t;
    t = a >> sh;
    flps_sector = t[2:0];
  endfunction : flps_sector
endpackage : flps_pkg
`default_nettype wire

// *** rtl/flps_op_timer.sv ***
// Duration counter for program and erase operations
`timescale 1ns/1ps
`default_nettype none
module flps_op_timer (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_start,
  input wire logic [15:0] i_len,
  output logic o_done
);
  import flps_pkg::*;
  logic [15:0] cnt_r;
  logic run_r;

  // Counts down the operation; done pulses on the last cycle
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_r <= FLPS_TIME_RESET;
      run_r <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        cnt_r <= i_len;
        run_r <= 1'b1;
      end else if (run_r) begin
        if (cnt_r <= 16'h0001) begin
          run_r <= 1'b0;
          o_done <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 16'h0001;
        end
      end
    end
  end
endmodule : flps_op_timer
`default_nettype wire

// *** rtl/flps_flash_protect.sv ***
// Flash protect, unlock and program/erase sequencer
`timescale 1ns/1ps
`default_nettype none
module flps_flash_protect #(
  parameter int FLASH_BYTES = 8192,
  parameter logic [15:0] PROG_CYCLES = 16'h0028,
  parameter logic [15:0] PERASE_CYCLES = 16'h0400,
  parameter logic [15:0] MERASE_CYCLES = 16'h0800
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_rf_wr,
  input wire logic i_rf_rd,
  input wire logic [11:0] i_rf_addr,
  input wire logic [7:0] i_rf_wdata,
  output logic [7:0] o_rf_rdata,
  input wire logic i_dbg_access,
  input wire logic i_write_guard_option_bit,
  input wire logic i_mem_wr,
  input wire logic [15:0] i_mem_addr,
  input wire logic [7:0] i_mem_wdata,
  output logic o_cpu_stall,
  output logic o_flash_prog,
  output logic o_flash_page_erase,
  output logic o_flash_mass_erase,
  output logic [15:0] o_flash_addr,
  output logic [7:0] o_flash_wdata,
  output logic [5:0] o_flash_state_code
);
  import flps_pkg::*;

  // Sector is an eighth of the array but never below one page
  localparam int SECT_RAW = FLASH_BYTES / FLPS_SECTORS;
  localparam int SECT_BYTES = (SECT_RAW < FLPS_PAGE_BYTES) ? FLPS_PAGE_BYTES : SECT_RAW; // R9
  localparam int SECT_SHIFT = $clog2(SECT_BYTES);

  flps_state_t state_r;
  logic [7:0] page_sel_r;
  logic [6:0] act_page_r;
  logic [7:0] sector_protect_bits_r;
  logic op_done;

  ////////////////////////////////////////////////////////////////////////////////
  // Request decode

  logic busy;
  logic ctl_wr;
  logic sel_wr;
  logic [7:0] cmd;
  logic guard_ok;
  logic [15:0] erase_addr;
  logic erase_ok;
  logic prog_ok;
  logic start_prog;
  logic start_perase;
  logic start_merase;
  logic page_match;

  // Register writes are dropped while an operation runs; the CPU is stalled then
  assign busy = (state_r == FLPS_PROG) || (state_r == FLPS_PERASE) || (state_r == FLPS_MERASE);
  assign ctl_wr = i_rf_wr && (i_rf_addr == FLPS_CTL_ADDR) && !busy;
  assign sel_wr = i_rf_wr && (i_rf_addr == FLPS_SEL_ADDR) && !busy;
  assign cmd = i_rf_wdata;
  assign page_match = (i_rf_wdata[6:0] == page_sel_r[6:0]);

  // Option bit gates user code only; debugger overrides it
  assign guard_ok = i_dbg_access || i_write_guard_option_bit; // R1 R2 R22

  // Page address from the page field
  assign erase_addr = {page_sel_r[6:0], FLPS_PAGE_OFS}; // R26
  assign erase_ok = guard_ok &&
    (i_dbg_access || !sector_protect_bits_r[flps_sector(erase_addr, SECT_SHIFT)]); // R6 R14

  // Byte store accepted in the open page, or anywhere for the debugger
  assign prog_ok = i_mem_wr && !i_rf_wr && (state_r == FLPS_OPEN) && guard_ok &&
    (i_dbg_access || !sector_protect_bits_r[flps_sector(i_mem_addr, SECT_SHIFT)]) &&
    (i_dbg_access || (i_mem_addr[15:FLPS_PAGE_LSB] == act_page_r)); // R8 R14 R22

  assign start_prog = prog_ok;
  assign start_perase = ctl_wr && (state_r == FLPS_OPEN) &&
    (cmd == FLPS_CMD_PERASE) && erase_ok; // R6
  assign start_merase = ctl_wr && (state_r == FLPS_OPEN) &&
    (cmd == FLPS_CMD_MERASE) && i_dbg_access; // R21

  ////////////////////////////////////////////////////////////////////////////////
  // Controller state

  // Unlock ladder, protect select, operations; reset leaves it locked
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= FLPS_LOCKED; // R3
    end else if (ctl_wr) begin
      if (cmd == FLPS_CMD_PROT) begin
        state_r <= FLPS_PROT; // R11
      end else begin
        case (state_r)
          FLPS_LOCKED: begin
            state_r <= (cmd == FLPS_CMD_UNL1) ? FLPS_GOT1 : FLPS_LOCKED;
          end
          FLPS_GOT1: begin
            if (cmd != FLPS_CMD_UNL2) begin
              state_r <= FLPS_LOCKED;
            end else begin
              state_r <= i_dbg_access ? FLPS_OPEN : FLPS_GOT2; // R23
            end
          end
          FLPS_OPEN: begin
            if (start_perase) begin
              state_r <= FLPS_PERASE;
            end else if (start_merase) begin
              state_r <= FLPS_MERASE;
            end else begin
              state_r <= FLPS_LOCKED; // R7
            end
          end
          default: begin
            state_r <= FLPS_LOCKED; // R12
          end
        endcase
      end
    end else if (sel_wr && (state_r == FLPS_GOT2)) begin
      state_r <= page_match ? FLPS_OPEN : FLPS_LOCKED; // R5
    end else if (start_prog) begin
      state_r <= FLPS_PROG;
    end else if (op_done) begin
      // Byte program keeps the page open; erases relock
      state_r <= (state_r == FLPS_PROG) ? FLPS_OPEN : FLPS_LOCKED; // R8 R20 R21
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Page selection and sector protection

  // Page select; user code cannot move it while a page is open
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      page_sel_r <= FLPS_SEL_RESET;
    end else if (sel_wr && (state_r != FLPS_PROT) &&
                 ((state_r != FLPS_OPEN) || i_dbg_access)) begin
      page_sel_r <= i_rf_wdata; // R23
    end
  end

  // Active page latched when the unlock completes
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      act_page_r <= 7'h00;
    end else if (sel_wr && (state_r == FLPS_GOT2) && page_match) begin
      act_page_r <= i_rf_wdata[6:0]; // R5
    end else if (ctl_wr && (state_r == FLPS_GOT1) && (cmd == FLPS_CMD_UNL2) && i_dbg_access) begin
      act_page_r <= page_sel_r[6:0]; // R23
    end
  end

  // Protect bits only set from user code; reset is the power cycle here
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sector_protect_bits_r <= FLPS_PROT_RESET; // R10
    end else if (sel_wr && (state_r == FLPS_PROT)) begin
      if (i_dbg_access) begin
        sector_protect_bits_r <= i_rf_wdata; // R22
      end else begin
        sector_protect_bits_r <= sector_protect_bits_r | i_rf_wdata; // R13 R15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Operation timing and array strobes

  logic [15:0] op_len;
  assign op_len = start_prog ? PROG_CYCLES : (start_perase ? PERASE_CYCLES : MERASE_CYCLES);

  flps_op_timer u_timer (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_start(start_prog || start_perase || start_merase),
    .i_len(op_len),
    .o_done(op_done)
  );

  // One-cycle strobes to the array; the array only pulls bits low on program
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_flash_prog <= 1'b0;
      o_flash_page_erase <= 1'b0;
      o_flash_mass_erase <= 1'b0;
      o_flash_addr <= 16'h0000;
      o_flash_wdata <= 8'hFF;
    end else begin
      o_flash_prog <= start_prog; // R17
      o_flash_page_erase <= start_perase; // R20
      o_flash_mass_erase <= start_merase; // R21
      if (start_prog) begin
        o_flash_addr <= i_mem_addr;
        o_flash_wdata <= i_mem_wdata;
      end else if (start_perase) begin
        o_flash_addr <= erase_addr; // R26
      end else if (start_merase) begin
        o_flash_addr <= 16'h0000;
      end
    end
  end

  // CPU held from operation start until the timer finishes
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_cpu_stall <= 1'b0;
    end else if (start_prog || start_perase || start_merase) begin
      o_cpu_stall <= 1'b1; // R19
    end else if (op_done) begin
      o_cpu_stall <= 1'b0; // R19
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register reads

  // Read data registered; shared address follows protect selection
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rf_rdata <= 8'h00;
      o_flash_state_code <= FLPS_ST_LOCKED;
    end else begin
      o_flash_state_code <= flps_status(state_r); // R25
      if (i_rf_rd) begin
        if (i_rf_addr == FLPS_CTL_ADDR) begin
          o_rf_rdata <= {FLPS_RSVD, flps_status(state_r)}; // R25
        end else if (i_rf_addr == FLPS_SEL_ADDR) begin
          o_rf_rdata <= (state_r == FLPS_PROT) ? sector_protect_bits_r : page_sel_r; // R11 R12
        end else begin
          o_rf_rdata <= 8'h00;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_first_code;
    ctl_wr && (state_r == FLPS_LOCKED) && (cmd == FLPS_CMD_UNL1);
  endsequence
  sequence s_second_code;
    ctl_wr && (state_r == FLPS_GOT1) && (cmd == FLPS_CMD_UNL2) && !i_dbg_access;
  endsequence
  sequence s_erase_go;
    ctl_wr && (state_r == FLPS_OPEN) && (cmd == FLPS_CMD_PERASE) && erase_ok;
  endsequence

  property p_unlock_seq;
    s_first_code ##[1:2] s_second_code |=> (state_r == FLPS_GOT2) ##1
      (o_flash_state_code == FLPS_ST_GOT2);
  endproperty
  a_unlock_seq: assert property (p_unlock_seq) else $error("unlock codes not tracked"); // R25

  property p_page_mismatch;
    sel_wr && (state_r == FLPS_GOT2) && !page_match |=> (state_r == FLPS_LOCKED);
  endproperty
  a_page_mismatch: assert property (p_page_mismatch) else $error("mismatch did not lock"); // R5

  property p_page_match;
    sel_wr && (state_r == FLPS_GOT2) && page_match |=>
      (state_r == FLPS_OPEN) && (act_page_r == $past(i_rf_wdata[6:0]));
  endproperty
  a_page_match: assert property (p_page_match) else $error("match did not open page"); // R5

  property p_relock;
    ctl_wr && (state_r == FLPS_OPEN) && (cmd != FLPS_CMD_PERASE) &&
      (cmd != FLPS_CMD_MERASE) && (cmd != FLPS_CMD_PROT) |=> (state_r == FLPS_LOCKED);
  endproperty
  a_relock: assert property (p_relock) else $error("stray command did not relock"); // R7

  property p_erase_stall;
    s_erase_go |=> o_flash_page_erase && o_cpu_stall ##1 o_cpu_stall[*3];
  endproperty
  a_erase_stall: assert property (p_erase_stall) else $error("erase did not stall cpu"); // R19

  property p_prot_sticky;
    !i_dbg_access |=> ((sector_protect_bits_r & $past(sector_protect_bits_r)) ==
      $past(sector_protect_bits_r));
  endproperty
  a_prot_sticky: assert property (p_prot_sticky) else $error("protect bit cleared"); // R13

  property p_user_guard;
    (o_flash_prog || o_flash_page_erase) && !$past(i_dbg_access) |->
      $past(i_write_guard_option_bit);
  endproperty
  a_user_guard: assert property (p_user_guard) else $error("write guard bypassed"); // R1

  property p_user_page;
    o_flash_prog && !$past(i_dbg_access) |->
      (o_flash_addr[15:FLPS_PAGE_LSB] == act_page_r) &&
      !sector_protect_bits_r[flps_sector(o_flash_addr, SECT_SHIFT)];
  endproperty
  a_user_page: assert property (p_user_page) else $error("program outside open page"); // R14

  property p_mass_dbg;
    o_flash_mass_erase |-> $past(i_dbg_access) && (o_flash_state_code == FLPS_ST_OPEN);
  endproperty
  a_mass_dbg: assert property (p_mass_dbg) else $error("mass erase without debugger"); // R21

  property p_done_relock;
    op_done && (state_r == FLPS_PERASE) |=> (state_r == FLPS_LOCKED) && !o_cpu_stall;
  endproperty
  a_done_relock: assert property (p_done_relock) else $error("erase did not relock"); // R20

  property p_prot_route;
    (state_r == FLPS_PROT) && i_rf_rd && (i_rf_addr == FLPS_SEL_ADDR) && !i_rf_wr
      |=> (o_rf_rdata == sector_protect_bits_r);
  endproperty
  a_prot_route: assert property (p_prot_route) else $error("protect not routed"); // R11

  property p_prot_deselect;
    ctl_wr && (state_r == FLPS_PROT) && (cmd != FLPS_CMD_PROT) |=> (state_r == FLPS_LOCKED);
  endproperty
  a_prot_deselect: assert property (p_prot_deselect) else $error("protect kept selected"); // R12

  property p_user_mass;
    ctl_wr && (state_r == FLPS_OPEN) && (cmd == FLPS_CMD_MERASE) && !i_dbg_access |=>
      (state_r == FLPS_LOCKED) && !o_flash_mass_erase;
  endproperty
  a_user_mass: assert property (p_user_mass) else $error("user mass erase not refused"); // R21

  property p_guard_block;
    ctl_wr && (state_r == FLPS_OPEN) && (cmd == FLPS_CMD_PERASE) && !i_dbg_access &&
      !i_write_guard_option_bit |=> (state_r == FLPS_LOCKED) && !o_flash_page_erase;
  endproperty
  a_guard_block: assert property (p_guard_block) else $error("guard did not block erase"); // R1

  property p_sector_block;
    ctl_wr && (state_r == FLPS_OPEN) && (cmd == FLPS_CMD_PERASE) && !i_dbg_access &&
      sector_protect_bits_r[flps_sector(erase_addr, SECT_SHIFT)] |=> !o_flash_page_erase;
  endproperty
  a_sector_block: assert property (p_sector_block) else $error("protected page erased"); // R14

  property p_prog_open;
    op_done && (state_r == FLPS_PROG) |=> (state_r == FLPS_OPEN) && !o_cpu_stall;
  endproperty
  a_prog_open: assert property (p_prog_open) else $error("program left page closed"); // R8

  property p_mass_relock;
    op_done && (state_r == FLPS_MERASE) |=> (state_r == FLPS_LOCKED) && !o_cpu_stall;
  endproperty
  a_mass_relock: assert property (p_mass_relock) else $error("mass erase did not relock"); // R21

  property p_stall_busy;
    busy |-> o_cpu_stall;
  endproperty
  a_stall_busy: assert property (p_stall_busy) else $error("cpu not stalled while busy"); // R19
endmodule : flps_flash_protect
`default_nettype wire

// *** dv/flps_array_model.sv ***
// Behavioural flash array seen behind the sequencer
`timescale 1ns/1ps
`default_nettype none
module flps_array_model
  import flps_pkg::*;
#(
  parameter int FLASH_BYTES = 8192
) (
  input wire logic i_clk,
  input wire logic i_prog,
  input wire logic i_page_erase,
  input wire logic i_mass_erase,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata
);
  logic [7:0] mem [FLASH_BYTES];
  int idx;
  int base;
  ////////////////////////////////////////////////////////////////
  // Array starts erased, all ones
  initial begin
    foreach (mem[k]) mem[k] = 8'hFF;
  end
  // Address wraps into the array; page base drops the in-page bits
  always @(posedge i_clk) begin
    idx = int'(i_addr) % FLASH_BYTES;
    base = idx - (idx % FLPS_PAGE_BYTES);
    if (i_prog === 1'b1) mem[idx] = mem[idx] & i_wdata;
    if (i_page_erase === 1'b1) begin
      for (int k = 0; k < FLPS_PAGE_BYTES; k++) mem[base + k] = 8'hFF;
    end
    if (i_mass_erase === 1'b1) begin
      foreach (mem[k]) mem[k] = 8'hFF;
    end
  end
endmodule : flps_array_model
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench for the flash protect and program/erase sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import flps_pkg::*;
  typedef struct {logic [11:0] a; logic [7:0] d; logic [5:0] st;} flps_row_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic rf_wr = 1'b0;
  logic rf_rd = 1'b0;
  logic [11:0] rf_addr = 12'h000;
  logic [7:0] rf_wdata = 8'h00;
  logic dbg = 1'b0;
  logic guard = 1'b1;
  logic mem_wr = 1'b0;
  logic [15:0] mem_addr = 16'h0000;
  logic [7:0] mem_wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] rd8;
  logic stall, fprog, fpe, fme;
  logic [15:0] faddr;
  logic [7:0] fwd;
  logic [5:0] code;
  int n_errors = 0;
  int checked = 0;
  int n_prog = 0;
  int n_pe = 0;
  int n_me = 0;
  // Command walk: unlock, page mismatch, relock, protect select and deselect
  flps_row_t rows[12] = '{
    '{FLPS_SEL_ADDR, 8'h02, FLPS_ST_LOCKED}, '{FLPS_CTL_ADDR, 8'h73, FLPS_ST_GOT1},
    '{FLPS_CTL_ADDR, 8'h8C, FLPS_ST_GOT2}, '{FLPS_SEL_ADDR, 8'h03, FLPS_ST_LOCKED},
    '{FLPS_SEL_ADDR, 8'h02, FLPS_ST_LOCKED}, '{FLPS_CTL_ADDR, 8'h73, FLPS_ST_GOT1},
    '{FLPS_CTL_ADDR, 8'h8C, FLPS_ST_GOT2}, '{FLPS_SEL_ADDR, 8'h02, FLPS_ST_OPEN},
    '{FLPS_CTL_ADDR, 8'h11, FLPS_ST_LOCKED}, '{FLPS_CTL_ADDR, 8'h5E, FLPS_ST_PROT},
    '{FLPS_CTL_ADDR, 8'h00, FLPS_ST_LOCKED}, '{FLPS_CTL_ADDR, 8'h73, FLPS_ST_GOT1}};
  ////////////////////////////////////////////////////////////////
  // 40 MHz clock
  always #12.5 clk = ~clk;
  // Short operation lengths keep the run brief
  flps_flash_protect #(.PROG_CYCLES(16'h0004), .PERASE_CYCLES(16'h0006),
    .MERASE_CYCLES(16'h0008)) flps_flash_protect_inst (.i_clk(clk), .i_rst_b(rst_b),
    .i_rf_wr(rf_wr), .i_rf_rd(rf_rd), .i_rf_addr(rf_addr), .i_rf_wdata(rf_wdata),
    .o_rf_rdata(rdata), .i_dbg_access(dbg), .i_write_guard_option_bit(guard),
    .i_mem_wr(mem_wr), .i_mem_addr(mem_addr), .i_mem_wdata(mem_wdata),
    .o_cpu_stall(stall), .o_flash_prog(fprog), .o_flash_page_erase(fpe),
    .o_flash_mass_erase(fme), .o_flash_addr(faddr), .o_flash_wdata(fwd),
    .o_flash_state_code(code));
  flps_array_model flps_array_model_inst (.i_clk(clk), .i_prog(fprog),
    .i_page_erase(fpe), .i_mass_erase(fme), .i_addr(faddr), .i_wdata(fwd));
  // Pulse counters, so a skipped or extra operation shows
  always @(posedge clk) begin
    if (fprog === 1'b1) n_prog++;
    if (fpe === 1'b1) n_pe++;
    if (fme === 1'b1) n_me++;
  end
  ////////////////////////////////////////////////////////////////
  // Compare helpers and verdict
  task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk_val
  task automatic chk_cnt(input string nm, input int e, input int g);
    checked++;
    if (g != e) begin
      n_errors++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_cnt
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////
  // Bus drivers, all launched on the falling edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    rf_addr = a;
    rf_wdata = d;
    rf_wr = 1'b1;
    @(negedge clk);
    rf_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(negedge clk);
    rf_addr = a;
    rf_rd = 1'b1;
    @(negedge clk);
    rf_rd = 1'b0;
    d = rdata;
  endtask : rd
  task automatic store(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    mem_addr = a;
    mem_wdata = d;
    mem_wr = 1'b1;
    @(negedge clk);
    mem_wr = 1'b0;
  endtask : store
  // Bounded wait for the stall to drop; state code lags by a cycle
  task automatic wait_idle;
    int k;
    k = 0;
    while (stall !== 1'b0 && k < 200) begin
      @(negedge clk);
      k++;
    end
    if (k == 200) chk_cnt("idle wait", 0, k);
    repeat (2) @(negedge clk);
  endtask : wait_idle
  // Debugger skips the repeated page write
  task automatic unlock(input logic [7:0] pg);
    wr(FLPS_SEL_ADDR, pg);
    wr(FLPS_CTL_ADDR, FLPS_CMD_UNL1);
    wr(FLPS_CTL_ADDR, FLPS_CMD_UNL2);
    if (dbg !== 1'b1) wr(FLPS_SEL_ADDR, pg);
    @(negedge clk);
    chk_val("open code", FLPS_ST_OPEN, code);
  endtask : unlock
  task automatic prot_sel;
    wr(FLPS_CTL_ADDR, 8'h00);
    wr(FLPS_CTL_ADDR, FLPS_CMD_PROT);
  endtask : prot_sel
  task automatic do_reset;
    @(negedge clk);
    rst_b = 1'b0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
  endtask : do_reset
  ////////////////////////////////////////////////////////////////
  // Watchdog, many tens of times the expected run
  initial begin
    #(25 * 20000);
    n_errors++;
    tally_and_finish;
  end
  // Main sequence
  initial begin
    do_reset;
    chk_val("reset code", FLPS_ST_LOCKED, code);
    rd(FLPS_SEL_ADDR, rd8);
    chk_val("page select", FLPS_SEL_RESET, rd8);
    rd(12'hF00, rd8);
    chk_val("unmapped read", 8'h00, rd8);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      @(negedge clk);
      chk_val("state code", rows[i].st, code);
    end
    wr(FLPS_CTL_ADDR, 8'h00);
    // Byte program twice in the open page, once outside it
    unlock(8'h02);
    store(16'h0410, 8'hA5);
    chk_val("stall", 1'b1, stall);
    chk_val("prog addr", 16'h0410, faddr);
    chk_val("prog data", 8'hA5, fwd);
    @(negedge clk);
    chk_val("prog code", FLPS_ST_PROG, code);
    wait_idle;
    chk_val("code after prog", FLPS_ST_OPEN, code);
    store(16'h0410, 8'h0F);
    wait_idle;
    chk_val("array byte", 8'h05, flps_array_model_inst.mem[16'h0410]);
    store(16'h0600, 8'h00);
    wait_idle;
    chk_cnt("prog count", 2, n_prog);
    // Page erase of the active page
    wr(FLPS_CTL_ADDR, FLPS_CMD_PERASE);
    chk_val("erase addr", 16'h0400, faddr);
    chk_val("erase stall", 1'b1, stall);
    wait_idle;
    chk_val("code after erase", FLPS_ST_LOCKED, code);
    chk_val("erased byte", 8'hFF, flps_array_model_inst.mem[16'h0410]);
    chk_cnt("erase count", 1, n_pe);
    // Guard option cleared blocks user program and erase
    guard = 1'b0;
    unlock(8'h02);
    store(16'h0410, 8'h00);
    wait_idle;
    wr(FLPS_CTL_ADDR, FLPS_CMD_PERASE);
    wait_idle;
    chk_cnt("guarded prog", 2, n_prog);
    chk_cnt("guarded erase", 1, n_pe);
    chk_val("relock code", FLPS_ST_LOCKED, code);
    guard = 1'b1;
    // User protect: set only, then protected sector refuses
    prot_sel;
    wr(FLPS_SEL_ADDR, 8'h04);
    wr(FLPS_SEL_ADDR, 8'h00);
    rd(FLPS_SEL_ADDR, rd8);
    chk_val("protect bits", 8'h04, rd8);
    wr(FLPS_CTL_ADDR, 8'h00);
    rd(FLPS_SEL_ADDR, rd8);
    chk_val("page select back", 8'h02, rd8);
    unlock(8'h04);
    store(16'h0810, 8'h00);
    wait_idle;
    wr(FLPS_CTL_ADDR, FLPS_CMD_PERASE);
    wait_idle;
    chk_cnt("protected prog", 2, n_prog);
    chk_cnt("protected erase", 1, n_pe);
    // Mass erase refused to user code
    unlock(8'h02);
    wr(FLPS_CTL_ADDR, FLPS_CMD_MERASE);
    wait_idle;
    chk_cnt("user mass erase", 0, n_me);
    chk_val("user mass code", FLPS_ST_LOCKED, code);
    // Debugger: no guard, no sector lock, any page, mass erase, clear protect
    dbg = 1'b1;
    guard = 1'b0;
    unlock(8'h04);
    store(16'h0A00, 8'h3C);
    wait_idle;
    chk_val("debug prog", 8'h3C, flps_array_model_inst.mem[16'h0A00]);
    wr(FLPS_CTL_ADDR, FLPS_CMD_MERASE);
    @(negedge clk);
    chk_val("mass code", FLPS_ST_MERASE, code);
    wait_idle;
    chk_cnt("mass count", 1, n_me);
    chk_val("mass relock", FLPS_ST_LOCKED, code);
    chk_val("mass byte", 8'hFF, flps_array_model_inst.mem[16'h0A00]);
    prot_sel;
    wr(FLPS_SEL_ADDR, 8'h00);
    rd(FLPS_SEL_ADDR, rd8);
    chk_val("debug clear", 8'h00, rd8);
    dbg = 1'b0;
    guard = 1'b1;
    // Reset mid-run drops protection and locks
    wr(FLPS_SEL_ADDR, 8'h80);
    do_reset;
    chk_val("code after reset", FLPS_ST_LOCKED, code);
    prot_sel;
    rd(FLPS_SEL_ADDR, rd8);
    chk_val("protect after reset", FLPS_PROT_RESET, rd8);
    wr(FLPS_CTL_ADDR, 8'h00);
    tally_and_finish;
  end
endmodule : tb_top
`default_nettype wire
